// File: hdl/scg_params.svh
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH
`define SCG_SW_OLD_CYC   2'd2
`define SCG_SW_NEW_CYC   2'd2
`define SCG_REF_DIV      5'd31
`define SCG_OSC_EN_RST   5'h01
`define SCG_MULTIPLIER_FACTOR_RST  5'h01
`define SCG_MULTIPLIER_FACTOR_MIN  5'h01
`define SCG_PSADIV_MAX   5'h11
`define SCG_EXTERNAL_OSC_SOURCE_MODE_RST 2'h0
`endif

// File: hdl/scg_pkg.sv
package scg_pkg;
    typedef enum logic [2:0] {
        SCG_RC2   = 3'h0,
        SCG_RC32  = 3'h1,
        SCG_RC32K = 3'h2,
        SCG_EXTERNAL_OSC_SOURCE  = 3'h3,
        SCG_PLL   = 3'h4
    } scg_src_t;
    typedef enum logic [1:0] {
        SCG_PREF_RC2    = 2'h0,
        SCG_PREF_RC32D4 = 2'h1,
        SCG_PREF_XTAL   = 2'h2,
        SCG_PREF_EXT    = 2'h3
    } scg_pll_src_t;
    typedef struct packed {
        scg_pll_src_t src;
        logic [4:0]   multiplier_factor;
    } scg_pll_cfg_t;
    typedef struct packed {
        logic [4:0] adiv;
        logic [1:0] bcdiv;
    } scg_ps_t;
    typedef enum logic [2:0] {
        SCG_SW_IDLE = 3'b001,
        SCG_SW_OLD  = 3'b010,
        SCG_SW_NEW  = 3'b100
    } scg_sw_st_t;
endpackage

// File: hdl/scg_clock_ctrl.sv
`timescale 1ns/1ps
`include "scg_params.svh"
// Overview of operation
// - Reset leaves system clock on 2MHz oscillator
// - Main crystal offers four frequency modes
// - Low-frequency crystal has low-power swing mode
// - Refuse unready select, refuse disabling active source
// - Prescaler chain divides 1 to 2048
// - First stage divides 1 to 512
// - Second, third stages pass or divide, up to 4
// - Settings apply on slowest clock edge, glitch-free
// - Selection, prescaler, monitor need protected write
// - Multiplier factor 1 through 31
// - Multiplier reference from four sources
// - Loop enabled blocks config and reference disable
// - Loop usable only when reference stable, locked
// - Calibration reference selectable, divided by 32
// - Compare loads ideal ratio, fast loop writable
// - Calibration steps one toward target on error
// - Calibration halts in sleep, keeps value
// - Calibration value writable while loop disabled
// - In-use failure falls back, flags, raises NMI
// - Idle-source failure disables it, no NMI
// - Monitor sticky, paused in sleep
// - Switch takes two old, two new cycles
module scg_clock_ctrl #(
    parameter int               CAL_W     = 8,
    parameter logic [15:0]      COMP_RST0 = 16'h07a1,
    parameter logic [15:0]      COMP_RST1 = 16'h7a12,
    parameter logic [CAL_W-1:0] CAL_RST   = 8'h40,
    parameter logic [15:0]      HALF_ERR  = 16'h0001
) (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_ccp_ok,
    input  wire logic                 i_wr_sel,
    input  scg_pkg::scg_src_t         i_sel_val,
    input  wire logic                 i_wr_ps,
    input  scg_pkg::scg_ps_t          i_ps_val,
    input  wire logic                 i_wr_osc,
    input  wire logic [4:0]           i_osc_en_val,
    input  wire logic                 i_wr_pll,
    input  scg_pkg::scg_pll_cfg_t     i_pll_val,
    input  wire logic                 i_wr_external_osc_source,
    input  wire logic [1:0]           i_external_osc_source_mode_val,
    input  wire logic                 i_lf_lowpwr_val,
    input  wire logic                 i_wr_fmon,
    input  wire logic [1:0]           i_fmon_val,
    input  wire logic [1:0]           i_clr_fail,
    input  wire logic [4:0]           i_osc_rdy,
    input  wire logic                 i_sleep_osc_stop,
    input  wire logic [3:0]           i_ref_tick,
    input  wire logic [1:0]           i_osc_tick,
    input  wire logic [1:0]           i_freq_calibration_loop_en,
    input  wire logic [3:0]           i_freq_calibration_loop_ref,
    input  wire logic [1:0]           i_wr_cal,
    input  wire logic [CAL_W-1:0]     i_cal_val,
    input  wire logic                 i_wr_comp,
    input  wire logic [15:0]          i_comp_val,
    output scg_pkg::scg_src_t         o_sys_clk_source_select,
    output logic                      o_sw_busy,
    output logic [4:0]                o_osc_en,
    output logic [4:0]                o_osc_rdy,
    output scg_pkg::scg_pll_cfg_t     o_pll_cfg,
    output logic [1:0]                o_external_osc_source_mode,
    output logic                      o_lf_lowpwr,
    output scg_pkg::scg_ps_t          o_ps,
    output logic                      o_periph_clk_x4_en,
    output logic                      o_periph_clk_x2_en,
    output logic                      o_periph_clk_en,
    output logic [1:0]                o_fmon_en,
    output logic [1:0]                o_fail_flag,
    output logic                      o_nmi,
    output logic [CAL_W-1:0]          o_cal0,
    output logic [CAL_W-1:0]          o_cal1
);
    import scg_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    function automatic scg_src_t pll_ref_idx(input scg_pll_src_t s);
        case (s)
            SCG_PREF_RC2:    pll_ref_idx = SCG_RC2;
            SCG_PREF_RC32D4: pll_ref_idx = SCG_RC32;
            default:         pll_ref_idx = SCG_EXTERNAL_OSC_SOURCE;
        endcase
    endfunction
    function automatic logic [8:0] adiv_lim(input logic [4:0] c);
        logic [9:0] p;
        p = 10'h001 << ((c + 5'h01) >> 1);
        adiv_lim = (c == 5'h00) ? 9'h000 : 9'(p - 10'h001);
    endfunction
    // Synchronisers: stage 2 and 3 read, stage 1 only feeds stage 2
    logic [10:0] s1_r, s2_r, s3_r;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 11'h000;
            s2_r <= 11'h000;
            s3_r <= 11'h000;
        end else begin
            s1_r <= {i_osc_tick, i_ref_tick, i_osc_rdy};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    logic [4:0] rdy;
    logic [3:0] ref_edge;
    logic [1:0] osc_edge;
    assign rdy      = s2_r[4:0];
    assign ref_edge = s2_r[8:5] & ~s3_r[8:5];
    assign osc_edge = s2_r[10:9] & ~s3_r[10:9];
    scg_src_t     sel_r, tgt_r;
    scg_sw_st_t   sw_st_r;
    logic [1:0]   sw_cnt_r;
    logic [4:0]   osc_en_r;
    scg_pll_cfg_t pll_cfg_r;
    logic         pll_ref_ok, sel_ok;
    logic [4:0]   src_ok, keep;
    logic [1:0]   fmon_r, seen_r, fail_det, in_use, fail_r;
    logic         fail_use, fail_any, nmi_r;
    assign pll_ref_ok = rdy[pll_ref_idx(pll_cfg_r.src)];
    always_comb begin
        src_ok = osc_en_r & rdy;
        src_ok[SCG_PLL] = src_ok[SCG_PLL] & pll_ref_ok;
    end
    // Clock source switching
    assign sel_ok = i_wr_sel && i_ccp_ok && (sw_st_r == SCG_SW_IDLE)
                 && (i_sel_val <= SCG_PLL) && src_ok[i_sel_val]
                 && (i_sel_val != sel_r);
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sel_r    <= SCG_RC2;
            tgt_r    <= SCG_RC2;
            sw_st_r  <= SCG_SW_IDLE;
            sw_cnt_r <= 2'd0;
        end else if (fail_use) begin
            sel_r    <= SCG_RC2;
            sw_st_r  <= SCG_SW_IDLE;
            sw_cnt_r <= 2'd0;
        end else begin
            case (sw_st_r)
                SCG_SW_IDLE: if (sel_ok) begin
                    tgt_r    <= i_sel_val;
                    sw_st_r  <= SCG_SW_OLD;
                    sw_cnt_r <= 2'd1;
                end
                SCG_SW_OLD: if (sw_cnt_r == `SCG_SW_OLD_CYC) begin
                    sel_r    <= tgt_r;
                    tgt_r    <= sel_r;
                    sw_st_r  <= SCG_SW_NEW;
                    sw_cnt_r <= 2'd1;
                end else begin
                    sw_cnt_r <= sw_cnt_r + 2'd1;
                end
                SCG_SW_NEW: if (sw_cnt_r == `SCG_SW_NEW_CYC) begin
                    sw_st_r  <= SCG_SW_IDLE;
                    sw_cnt_r <= 2'd0;
                end else begin
                    sw_cnt_r <= sw_cnt_r + 2'd1;
                end
                default: sw_st_r <= SCG_SW_IDLE;
            endcase
        end
    end
    // Sources that may not be turned off right now
    always_comb begin
        keep = 5'h00;
        keep[sel_r] = 1'b1;
        if (sw_st_r != SCG_SW_IDLE)
            keep[tgt_r] = 1'b1;
        if (osc_en_r[SCG_PLL])
            keep[pll_ref_idx(pll_cfg_r.src)] = 1'b1;
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            osc_en_r <= `SCG_OSC_EN_RST;
        else if (fail_use)
            osc_en_r <= `SCG_OSC_EN_RST;
        else if (|fail_det) begin
            if (fail_det[0])
                osc_en_r[SCG_PLL] <= 1'b0;
            if (fail_det[1])
                osc_en_r[SCG_EXTERNAL_OSC_SOURCE] <= 1'b0;
        end else if (i_wr_osc)
            osc_en_r <= i_osc_en_val | keep;
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            pll_cfg_r <= '{src: SCG_PREF_RC2, multiplier_factor: `SCG_MULTIPLIER_FACTOR_RST};
        else if (i_wr_pll && !osc_en_r[SCG_PLL]
                 && i_pll_val.multiplier_factor >= `SCG_MULTIPLIER_FACTOR_MIN)
            pll_cfg_r <= i_pll_val;
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_external_osc_source_mode <= `SCG_EXTERNAL_OSC_SOURCE_MODE_RST;
            o_lf_lowpwr <= 1'b0;
        end else if (i_wr_external_osc_source && !osc_en_r[SCG_EXTERNAL_OSC_SOURCE]) begin
            o_external_osc_source_mode <= i_external_osc_source_mode_val;
            o_lf_lowpwr <= i_lf_lowpwr_val;
        end
    end
    // Prescaler chain, new setting applied on the slowest tick
    scg_ps_t    ps_act_r, ps_pend_r;
    logic [8:0] a_cnt_r, a_lim;
    logic [1:0] b_cnt_r, b_lim;
    logic       c_cnt_r, c_lim, per4_en, per2_en, per_en, ps_code_ok;
    assign a_lim   = adiv_lim(ps_act_r.adiv);
    assign b_lim   = (ps_act_r.bcdiv == 2'b10) ? 2'd3 : {1'b0, &ps_act_r.bcdiv};
    assign c_lim   = ps_act_r.bcdiv[0];
    assign per4_en = (a_cnt_r == a_lim);
    assign per2_en = per4_en && (b_cnt_r == b_lim);
    assign per_en  = per2_en && (c_cnt_r == c_lim);
    assign ps_code_ok = (i_ps_val.adiv == 5'h00)
                     || (i_ps_val.adiv[0] && i_ps_val.adiv <= `SCG_PSADIV_MAX);
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            ps_pend_r <= '0;
        else if (i_wr_ps && i_ccp_ok && ps_code_ok)
            ps_pend_r <= i_ps_val;
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            ps_act_r <= '0;
        else if (per_en)
            ps_act_r <= ps_pend_r;
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            a_cnt_r <= 9'h000;
            b_cnt_r <= 2'd0;
            c_cnt_r <= 1'b0;
        end else begin
            a_cnt_r <= per4_en ? 9'h000 : a_cnt_r + 9'h001;
            if (per4_en)
                b_cnt_r <= per2_en ? 2'd0 : b_cnt_r + 2'd1;
            if (per2_en)
                c_cnt_r <= per_en ? 1'b0 : ~c_cnt_r;
        end
    end
    // Failure monitor: bit 0 multiplier loop, bit 1 external source
    assign in_use[0] = (sel_r == SCG_PLL);
    assign in_use[1] = (sel_r == SCG_EXTERNAL_OSC_SOURCE);
    always_comb begin
        fail_det[0] = fmon_r[0] && osc_en_r[SCG_PLL] && seen_r[0] && !rdy[SCG_PLL];
        fail_det[1] = fmon_r[1] && osc_en_r[SCG_EXTERNAL_OSC_SOURCE] && seen_r[1] && !rdy[SCG_EXTERNAL_OSC_SOURCE];
        fail_det    = fail_det & {2{!i_sleep_osc_stop}};
    end
    assign fail_use = |(fail_det & in_use);
    assign fail_any = |fail_det;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            fmon_r <= 2'b00;
        else if (i_wr_fmon && i_ccp_ok)
            fmon_r <= fmon_r | i_fmon_val;
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            seen_r <= 2'b00;
        else if (i_sleep_osc_stop)
            seen_r <= 2'b00;
        else
            seen_r <= {osc_en_r[SCG_EXTERNAL_OSC_SOURCE] & (seen_r[1] | rdy[SCG_EXTERNAL_OSC_SOURCE]),
                       osc_en_r[SCG_PLL] & (seen_r[0] | rdy[SCG_PLL])} & ~fail_det;
    end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            fail_r <= 2'b00;
            nmi_r  <= 1'b0;
        end else begin
            fail_r <= (fail_r & ~i_clr_fail) | (fail_det & in_use);
            nmi_r  <= fail_use;
        end
    end
    // Calibration loops: 0 for 2MHz, 1 for 32MHz
    logic [CAL_W-1:0] cal_r [2];
    logic [15:0]      comp_r [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_freq_calibration_loop
            logic [4:0]  div_r;
            logic [15:0] cnt_r;
            logic        run, rtick, win_end, fast, slow;
            assign run     = i_freq_calibration_loop_en[g] && !i_sleep_osc_stop;
            assign rtick   = ref_edge[i_freq_calibration_loop_ref[2*g +: 2]];
            assign win_end = run && rtick && (div_r == `SCG_REF_DIV);
            assign fast = {1'b0, cnt_r} > ({1'b0, comp_r[g]} + {1'b0, HALF_ERR});
            assign slow = ({1'b0, cnt_r} + {1'b0, HALF_ERR}) < {1'b0, comp_r[g]};
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst) begin
                    div_r <= 5'd0;
                    cnt_r <= 16'h0000;
                end else if (!run) begin
                    div_r <= 5'd0;
                    cnt_r <= 16'h0000;
                end else begin
                    if (rtick)
                        div_r <= div_r + 5'd1;
                    if (win_end)
                        cnt_r <= 16'h0000;
                    else if (osc_edge[g] && cnt_r != 16'hffff)
                        cnt_r <= cnt_r + 16'h0001;
                end
            end
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst)
                    comp_r[g] <= (g == 0) ? COMP_RST0 : COMP_RST1;
                else if (g == 1 && i_wr_comp)
                    comp_r[g] <= i_comp_val;
            end
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst)
                    cal_r[g] <= CAL_RST;
                else if (!i_freq_calibration_loop_en[g] && i_wr_cal[g])
                    cal_r[g] <= i_cal_val;
                else if (win_end && fast && cal_r[g] != '0)
                    cal_r[g] <= cal_r[g] - 1'b1;
                else if (win_end && slow && cal_r[g] != '1)
                    cal_r[g] <= cal_r[g] + 1'b1;
            end
            a_cal_step: assert property (($changed(cal_r[g]) && $past(i_freq_calibration_loop_en[g]))
                |-> (CAL_W'(cal_r[g] - $past(cal_r[g])) == CAL_W'(1)
                  || CAL_W'($past(cal_r[g]) - cal_r[g]) == CAL_W'(1)))
                else $error("calibration moved by more than one step");
            a_cal_sleep: assert property (i_sleep_osc_stop |=> $stable(cal_r[g])
                || $past(i_wr_cal[g]))
                else $error("calibration moved during sleep");
            a_cal_manual: assert property ((i_wr_cal[g] && !i_freq_calibration_loop_en[g])
                |=> cal_r[g] == $past(i_cal_val))
                else $error("manual calibration write lost");
        end
    endgenerate
    a_boot_rc2: assert property ($past(i_rst) |-> sel_r == SCG_RC2
        && osc_en_r == `SCG_OSC_EN_RST)
        else $error("not on 2MHz source after reset");
    a_refuse_sel: assert property ((sw_st_r == SCG_SW_IDLE && i_wr_sel
        && !src_ok[i_sel_val]) |=> sw_st_r == SCG_SW_IDLE)
        else $error("switch to unready source accepted");
    a_keep_active: assert property (!fail_any |=> osc_en_r[$past(sel_r)])
        else $error("active source disabled");
    a_keep_old: assert property ((sw_st_r != SCG_SW_IDLE && !fail_any)
        |=> osc_en_r[$past(tgt_r)]) else $error("switching source disabled");
    a_switch_seq: assert property (@(posedge i_sys_clk) disable iff (i_rst || fail_any)
        sel_ok |=> sw_st_r == SCG_SW_OLD [*2] ##1 sw_st_r == SCG_SW_NEW [*2]
        ##1 sw_st_r == SCG_SW_IDLE)
        else $error("switch sequence length wrong");
    a_no_ccp_sel: assert property ((i_wr_sel && !i_ccp_ok && sw_st_r == SCG_SW_IDLE)
        |=> sw_st_r == SCG_SW_IDLE)
        else $error("unprotected selection accepted");
    a_ps_on_slow: assert property ($changed(ps_act_r) |-> $past(per_en))
        else $error("prescaler changed off slowest edge");
    a_per_nest: assert property (per_en |-> per2_en && per4_en)
        else $error("derived clocks out of phase");
    a_per4_gap: assert property ((per4_en && a_lim != 9'h000
        && !(per_en && ps_pend_r.adiv == 5'h00)) |=> !per4_en)
        else $error("4x tick too frequent");
    a_pll_cfg_lock: assert property (osc_en_r[SCG_PLL] |=> $stable(pll_cfg_r))
        else $error("loop config changed while enabled");
    a_pll_ready: assert property ((sel_ok && i_sel_val == SCG_PLL)
        |-> rdy[SCG_PLL] && pll_ref_ok)
        else $error("loop selected before lock");
    a_fail_nmi: assert property (fail_use |=> sel_r == SCG_RC2 && nmi_r
        && osc_en_r == `SCG_OSC_EN_RST && |fail_r)
        else $error("in-use failure not handled");
    a_fail_quiet: assert property ((fail_any && !fail_use && sw_st_r == SCG_SW_IDLE)
        |=> !nmi_r && $stable(sel_r))
        else $error("idle-source failure disturbed clock");
    a_fmon_sticky: assert property (fmon_r[0] |=> fmon_r[0])
        else $error("failure monitor dropped");
    c_switch_pll: cover property (sel_ok && i_sel_val == SCG_PLL);
    c_fail_use:   cover property (fail_use);
    c_ps_apply:   cover property (per_en && ps_pend_r != ps_act_r);
    c_cal_step:   cover property (g_freq_calibration_loop[1].win_end && g_freq_calibration_loop[1].fast);
    assign o_sys_clk_source_select = sel_r;
    assign o_sw_busy               = (sw_st_r != SCG_SW_IDLE);
    assign o_osc_en                = osc_en_r;
    assign o_osc_rdy               = src_ok;
    assign o_pll_cfg               = pll_cfg_r;
    assign o_ps                    = ps_act_r;
    assign o_periph_clk_x4_en      = per4_en;
    assign o_periph_clk_x2_en      = per2_en;
    assign o_periph_clk_en         = per_en;
    assign o_fmon_en               = fmon_r;
    assign o_fail_flag             = fail_r;
    assign o_nmi                   = nmi_r;
    assign o_cal0                  = cal_r[0];
    assign o_cal1                  = cal_r[1];
endmodule // scg_clock_ctrl

// File: testbench/scg_osc_model.sv
`timescale 1ns/1ps
// Oscillators, crystal and loop seen from the device pins
module scg_osc_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [4:0] i_osc_en,
    input  wire logic [1:0] i_fail,
    output logic      [4:0] o_rdy,
    output logic      [3:0] o_ref_tick,
    output logic      [1:0] o_osc_tick
);
    logic [3:0] wait_r [5];
    logic [7:0] div_r;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            div_r <= 8'h00;
            for (int k = 0; k < 5; k++)
                wait_r[k] <= 4'h0;
        end else begin
            div_r <= div_r + 8'h01;
            for (int k = 0; k < 5; k++)
                wait_r[k] <= !i_osc_en[k] ? 4'h0 : wait_r[k] + 4'(wait_r[k] != 4'hf);
        end
    end
    // Ready or lock only after start-up; forced failure drops it
    always_comb begin
        for (int k = 0; k < 5; k++)
            o_rdy[k] = (wait_r[k] == 4'hf) && !(k == 4 && i_fail[0]) && !(k == 3 && i_fail[1]);
    end
    assign o_ref_tick = {4{div_r[5]}};
    assign o_osc_tick = {2{div_r[1]}};
endmodule // scg_osc_model

// File: testbench/scg_clock_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) begin \
            miscompares++; \
            $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); \
        end \
    end
module scg_clock_ctrl_tb;
    import scg_pkg::*;
    logic         clk, rst, ccp, lp, slp, wcomp, t4, t2, tp, busy, nmi, lfp, nmi_seen;
    logic [5:0]   wr;
    scg_src_t     sel, src;
    scg_ps_t      ps, ops, last;
    scg_pll_cfg_t pv, pcfg, plast;
    logic [4:0]   oen, rdy, en, ordy;
    logic [1:0]   xm, fm, clr, fail, den, wcal, ot, xmode, fmen, ff;
    logic [3:0]   rt, dref;
    logic [7:0]   cv, c0, c1, old;
    logic [15:0]  comp;
    logic [2:0]   tk;
    int           comparisons, miscompares, n, k, a, b;
    localparam logic [5:0] M_SEL = 6'h20, M_PS = 6'h10, M_OSC = 6'h08;
    localparam logic [5:0] M_PLL = 6'h04, M_X = 6'h02, M_FM = 6'h01;
    assign tk = {tp, t2, t4};
    scg_clock_ctrl #(.COMP_RST0(16'h0258)) scg_clock_ctrl_i (
        .i_sys_clk(clk), .i_rst(rst), .i_ccp_ok(ccp), .i_wr_sel(wr[5]), .i_sel_val(sel),
        .i_wr_ps(wr[4]), .i_ps_val(ps), .i_wr_osc(wr[3]), .i_osc_en_val(oen),
        .i_wr_pll(wr[2]), .i_pll_val(pv), .i_wr_external_osc_source(wr[1]), .i_external_osc_source_mode_val(xm),
        .i_lf_lowpwr_val(lp), .i_wr_fmon(wr[0]), .i_fmon_val(fm), .i_clr_fail(clr),
        .i_osc_rdy(rdy), .i_sleep_osc_stop(slp), .i_ref_tick(rt), .i_osc_tick(ot),
        .i_freq_calibration_loop_en(den), .i_freq_calibration_loop_ref(dref), .i_wr_cal(wcal), .i_cal_val(cv),
        .i_wr_comp(wcomp), .i_comp_val(comp), .o_sys_clk_source_select(src),
        .o_sw_busy(busy), .o_osc_en(en), .o_osc_rdy(ordy), .o_pll_cfg(pcfg),
        .o_external_osc_source_mode(xmode), .o_lf_lowpwr(lfp), .o_ps(ops), .o_periph_clk_x4_en(t4),
        .o_periph_clk_x2_en(t2), .o_periph_clk_en(tp), .o_fmon_en(fmen),
        .o_fail_flag(ff), .o_nmi(nmi), .o_cal0(c0), .o_cal1(c1));
    scg_osc_model scg_osc_model_i (.i_sys_clk(clk), .i_rst(rst), .i_osc_en(en),
        .i_fail(fail), .o_rdy(rdy), .o_ref_tick(rt), .o_osc_tick(ot));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (nmi === 1'b1) nmi_seen <= 1'b1;
    function automatic int xdiv(input int v);
        return v == 0 ? 1 : 1 << ((v + 1) / 2);
    endfunction
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        wr <= m;
        @(posedge clk);
        wr <= 6'h00;
        #1;
    endtask
    task automatic period(input int s, output int p);
        for (p = 0; p < 5000 && tk[s] !== 1'b1; p++) cyc(1);
        p = 0;
        do begin
            cyc(1);
            p++;
        end while (tk[s] !== 1'b1 && p < 5000);
    endtask
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #500000;
        miscompares++;
        test_done();
    end
    initial begin
        {ccp, wr, ps, oen, pv, xm, lp, fm, clr, fail, slp, den, dref, wcal, cv, wcomp} = '0;
        comp = 16'h0000;
        sel = SCG_RC2;
        nmi_seen = 1'b0;
        rst = 1'b1;
        void'($urandom(89892));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        `CHK(src, SCG_RC2)
        `CHK(en, 5'h01)
        `CHK(ops, 7'h00)
        for (int m = 0; m < 4; m++) begin
            xm <= 2'(m);
            lp <= m[0];
            pulse(M_X);
            `CHK(xmode, 2'(m))
            `CHK(lfp, m[0])
        end
        cyc(20);
        ccp <= 1'b1;
        sel <= SCG_EXTERNAL_OSC_SOURCE;
        pulse(M_SEL);
        cyc(6);
        `CHK(src, SCG_RC2)
        oen <= 5'h03;
        pulse(M_OSC);
        for (n = 0; n < 100 && ordy[1] !== 1'b1; n++) cyc(1);
        ccp <= 1'b0;
        sel <= SCG_RC32;
        pulse(M_SEL);
        cyc(6);
        `CHK(src, SCG_RC2)
        ccp <= 1'b1;
        pulse(M_SEL);
        for (int i = 0; i < 5; i++) begin
            `CHK(busy, i < 4)
            `CHK(src, i < 2 ? SCG_RC2 : SCG_RC32)
            cyc(1);
        end
        oen <= 5'h01;
        pulse(M_OSC);
        `CHK(en[1], 1'b1)
        for (int i = 0; i < 5; i++) begin
            k = i == 0 ? 9 : $urandom_range(0, 6);
            a = k == 0 ? 0 : 2 * k - 1;
            b = i == 0 ? 2 : $urandom_range(0, 3);
            ps <= {5'(a), 2'(b)};
            pulse(M_PS);
            for (n = 0; n < 5000 && ops !== ps; n++) cyc(1);
            `CHK(ops, ps)
            period(0, n);
            `CHK(n, xdiv(a))
            period(1, n);
            `CHK(n, xdiv(a) * (b == 2 ? 4 : b == 3 ? 2 : 1))
            period(2, n);
            `CHK(n, xdiv(a) * (b == 0 ? 1 : b == 1 ? 2 : 4))
            `CHK(tk, 3'b111)
        end
        last = ops;
        ps <= {5'h15, 2'b00};
        pulse(M_PS);
        cyc(4200);
        `CHK(ops, last)
        // Reference first, then factor, then wait stable, then loop
        oen <= 5'h09;
        pulse(M_OSC);
        for (int s = 0; s < 4; s++) begin
            pv <= {2'(s), 5'($urandom_range(1, 31))};
            pulse(M_PLL);
            `CHK(pcfg, pv)
        end
        plast = pcfg;
        pv <= 7'h00;
        pulse(M_PLL);
        `CHK(pcfg, plast)
        pv <= 7'h1f;
        pulse(M_PLL);
        `CHK(pcfg, 7'h1f)
        for (n = 0; n < 100 && ordy[3] !== 1'b1; n++) cyc(1);
        oen <= 5'h19;
        pulse(M_OSC);
        sel <= SCG_PLL;
        pulse(M_SEL);
        cyc(5);
        `CHK(src, SCG_RC32)
        pv <= 7'h25;
        pulse(M_PLL);
        `CHK(pcfg, 7'h1f)
        oen <= 5'h18;
        pulse(M_OSC);
        `CHK(en[0], 1'b1)
        for (n = 0; n < 100 && ordy[4] !== 1'b1; n++) cyc(1);
        fm <= 2'b11;
        pulse(M_FM);
        pulse(M_SEL);
        cyc(5);
        `CHK(src, SCG_PLL)
        nmi_seen = 1'b0;
        fail <= 2'b10;
        for (n = 0; n < 50 && en[3] !== 1'b0; n++) cyc(1);
        cyc(4);
        `CHK(en[3], 1'b0)
        `CHK(src, SCG_PLL)
        `CHK({nmi_seen, ff}, 3'b000)
        fail <= 2'b11;
        for (n = 0; n < 50 && src !== SCG_RC2; n++) cyc(1);
        cyc(2);
        `CHK(en, 5'h01)
        `CHK({nmi_seen, ff}, 3'b101)
        clr <= 2'b01;
        cyc(1);
        clr <= 2'b00;
        `CHK(ff, 2'b00)
        fm <= 2'b00;
        pulse(M_FM);
        `CHK(fmen, 2'b11)
        cv <= 8'($urandom_range(0, 253));
        wcal <= 2'b11;
        cyc(1);
        wcal <= 2'b00;
        cyc(1);
        `CHK({c0, c1}, {cv, cv})
        old = c0;
        den <= 2'b01;
        cv <= ~old;
        wcal <= 2'b01;
        cyc(1);
        wcal <= 2'b00;
        cyc(1);
        `CHK(c0, old)
        for (n = 0; n < 5000 && c0 === old; n++) cyc(1);
        `CHK(c0, old + 8'h01)
        old = c0;
        slp <= 1'b1;
        cyc(4200);
        `CHK(c0, old)
        slp <= 1'b0;
        for (n = 0; n < 5000 && c0 === old; n++) cyc(1);
        `CHK(c0, old + 8'h01)
        test_done();
    end
endmodule // scg_clock_ctrl_tb
